// ---- hdl/uart1_defines.vh ----
// Constants shared by the serial port 1 control block
`ifndef UART1_DEFINES_VH
`define UART1_DEFINES_VH

// Special-function addresses
`define UART1_CTRL_ADDR 8'hF8
`define UART1_BUF_ADDR 8'h9A

// Reset values and byte constants
`define UART1_CTRL_RESET 8'h00
`define UART1_BYTE_ZERO 8'h00
`define UART1_BYTE_ONES 8'hFF

// Control field positions
`define BIT_MODE_HI 7
`define BIT_MODE_LO 6
`define BIT_MP_EN 5
`define BIT_RX_EN 4
`define BIT_TX_NINTH 3
`define BIT_RX_NINTH 2
`define BIT_TX_DONE 1
`define BIT_RX_DONE 0

// Operating modes
`define MODE0 2'h0
`define MODE1 2'h1
`define MODE2 2'h2
`define MODE3 2'h3

// Frame lengths in bit times, counted from the first bit shifted
`define LEN_SYNC 4'h8
`define LEN_M1 4'hA
`define LEN_M23 4'hB
`define DONE_M1 4'h9
`define DONE_M23 4'hA
`define RX_LEN_M1 4'h9
`define RX_LEN_M23 4'hA
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define CNT_DATA_END 4'h8

// Transmit queue
`define TXQ_WIDTH 8
`define TXQ_DEPTH 16

`endif

// ---- hdl/uart1_fifo.v ----
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module uart1_fifo #(
	parameter W = 8,
	parameter D = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire i_clk,
	input wire i_rst,
	// Fill side
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [W-1:0] i_in_data,
	// Drain side
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [W-1:0] o_out_data
);
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;

	assign o_in_ready = (count_r != D[AW:0]);
	assign o_out_valid = (count_r != {(AW+1){1'b0}});
	assign o_out_data = mem[rd_ptr_r];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	// Storage has no reset; the pointers and count_r define what is valid
	always @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr_r] <= i_in_data;
		end
	end

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule // uart1_fifo

`default_nettype wire

// ---- hdl/uart1_ctrl.v ----
// Serial port 1 control register, flags and frame engines
// Overview of operation
// - Bits 7 and 6 select mode normally
// - View select: bit 7 is sticky frame error
// - Address check ignored in mode 0
// - Mode 1 check: stop one and address match
// - Modes 2/3 check: ninth one and match
// - Receive enable gates all reception
// - Mode 0 receive needs enable, done clear
// - Ninth transmit bit sent in modes 2/3
// - Ninth received bit loaded in modes 2/3
// - Mode 1 ninth status holds stop bit
// - Transmit done set after last data bit
// - Receive done set; suppressed when check rejects
// - Enabled flags raise port interrupt request
// - Control resets zero, byte and bit access
// - Separate select steers bit 7 access
// - Buffer write transmits, read returns receive
`timescale 1ns/1ps
`default_nettype none
`include "uart1_defines.vh"

module uart1_ctrl #(
	parameter TXQ_W = `TXQ_WIDTH,
	parameter TXQ_D = `TXQ_DEPTH,
	parameter TXQ_AW = 4
) (
	// Clock and reset
	input wire i_clk,
	input wire i_rst,
	// Special-function register port
	input wire [7:0] i_sfr_addr,
	input wire i_sfr_wr,
	input wire [7:0] i_sfr_wdata,
	input wire i_sfr_rd,
	output reg [7:0] o_sfr_rdata,
	output wire o_txq_ready,
	// Bit-addressed write
	input wire i_bit_wr,
	input wire [7:0] i_bit_addr,
	input wire [2:0] i_bit_sel,
	input wire i_bit_val,
	// Settings held elsewhere
	input wire i_frame_err_view_sel,
	input wire i_uart1_int_en,
	input wire [7:0] i_slave_addr,
	input wire [7:0] i_slave_mask,
	// Bit timing
	input wire i_bit_tick,
	// Line
	input wire i_rxd,
	output reg o_txd,
	output reg o_sclk,
	// Interrupt
	output wire o_irq
);
	localparam TX_IDLE = 1'b0;
	localparam TX_SHIFT = 1'b1;
	localparam RX_IDLE = 1'b0;
	localparam RX_SHIFT = 1'b1;

	// Control fields
	reg mode_select_hi_r;
	reg frame_error_flag_r;
	reg mode_select_lo_r;
	reg multiproc_check_en_r;
	reg rx_en_r;
	reg tx_ninth_bit_r;
	reg rx_ninth_bit_r;
	reg tx_done_flag_r;
	reg rx_done_flag_r;
	reg mode_select_hi_nxt;
	reg frame_error_flag_nxt;
	reg mode_select_lo_nxt;
	reg multiproc_check_en_nxt;
	reg rx_en_nxt;
	reg tx_ninth_bit_nxt;
	reg rx_ninth_bit_nxt;
	reg tx_done_flag_nxt;
	reg rx_done_flag_nxt;

	// Write decode
	wire ctrl_byte_wr;
	wire ctrl_bit_wr;
	wire buf_wr;
	wire buf_rd;
	wire ctrl_rd;
	reg [7:0] wr_mask;
	reg [7:0] wr_data;
	wire [1:0] mode;
	wire [7:0] ctrl_view;

	// Transmit engine
	reg tx_state_r;
	reg [10:0] tx_shift_r;
	reg [3:0] tx_cnt_r;
	reg [3:0] tx_len_r;
	reg [3:0] tx_done_at_r;
	wire txq_valid;
	wire txq_pop;
	wire [7:0] txq_data;
	wire tx_done_evt;
	reg [10:0] tx_frame;

	// Receive engine
	reg rx_state_r;
	reg [3:0] rx_cnt_r;
	reg [3:0] rx_len_r;
	reg [7:0] rx_shift_r;
	reg rx_bit8_r;
	reg [7:0] rx_buf_r;
	wire rx_start;
	wire rx_last;
	wire addr_given;
	wire addr_bcast;
	wire addr_match;
	reg rx_valid;
	reg rx_load;
	reg rx_ninth_val;
	reg rx_ninth_load;
	reg fe_evt;

	assign mode = {mode_select_hi_r, mode_select_lo_r};
	assign ctrl_byte_wr = i_sfr_wr && (i_sfr_addr == `UART1_CTRL_ADDR);
	assign ctrl_bit_wr = i_bit_wr && (i_bit_addr == `UART1_CTRL_ADDR);
	assign buf_wr = i_sfr_wr && (i_sfr_addr == `UART1_BUF_ADDR);
	assign buf_rd = i_sfr_rd && (i_sfr_addr == `UART1_BUF_ADDR);
	assign ctrl_rd = i_sfr_rd && (i_sfr_addr == `UART1_CTRL_ADDR);

	// Bit 7 shows whichever field the view select picks
	assign ctrl_view = {
		i_frame_err_view_sel ? frame_error_flag_r : mode_select_hi_r,
		mode_select_lo_r,
		multiproc_check_en_r,
		rx_en_r,
		tx_ninth_bit_r,
		rx_ninth_bit_r,
		tx_done_flag_r,
		rx_done_flag_r
	};

	// Byte writes touch all bits; bit writes touch one
	always @* begin
		wr_mask = `UART1_BYTE_ZERO;
		wr_data = `UART1_BYTE_ZERO;
		if (ctrl_byte_wr) begin
			wr_mask = `UART1_BYTE_ONES;
			wr_data = i_sfr_wdata;
		end else if (ctrl_bit_wr) begin
			wr_mask[i_bit_sel] = 1'b1;
			wr_data = {8{i_bit_val}};
		end
	end

	// Address check on the received byte
	assign addr_given = ((rx_shift_r ^ i_slave_addr) & i_slave_mask) == `UART1_BYTE_ZERO;
	assign addr_bcast = ((~rx_shift_r) & (i_slave_addr | i_slave_mask)) == `UART1_BYTE_ZERO;
	assign addr_match = addr_given || addr_bcast;

	// End-of-frame decisions
	assign rx_last = (rx_state_r == RX_SHIFT) && rx_en_r && i_bit_tick && (rx_cnt_r == rx_len_r - `CNT_ONE);
	always @* begin
		rx_valid = 1'b0;
		rx_load = 1'b0;
		rx_ninth_val = 1'b0;
		rx_ninth_load = 1'b0;
		fe_evt = 1'b0;
		if (rx_last) begin
			case (mode)
				`MODE0: begin
					rx_valid = 1'b1;
				end
				`MODE1: begin
					rx_valid = !multiproc_check_en_r || (i_rxd && addr_match);
					rx_ninth_val = i_rxd;
					rx_ninth_load = rx_valid;
					fe_evt = !i_rxd;
				end
				`MODE2, `MODE3: begin
					rx_valid = !multiproc_check_en_r || (rx_bit8_r && addr_match);
					rx_ninth_val = rx_bit8_r;
					rx_ninth_load = rx_valid;
					fe_evt = !i_rxd;
				end
				default: begin
					rx_valid = 1'b0;
				end
			endcase
			rx_load = rx_valid;
		end
	end

	// Next control state; hardware events win over a same-cycle clear
	always @* begin
		mode_select_hi_nxt = mode_select_hi_r;
		frame_error_flag_nxt = frame_error_flag_r;
		if (wr_mask[`BIT_MODE_HI]) begin
			if (i_frame_err_view_sel) begin
				frame_error_flag_nxt = wr_data[`BIT_MODE_HI];
			end else begin
				mode_select_hi_nxt = wr_data[`BIT_MODE_HI];
			end
		end
		if (fe_evt) begin
			frame_error_flag_nxt = 1'b1;
		end
		mode_select_lo_nxt = wr_mask[`BIT_MODE_LO] ? wr_data[`BIT_MODE_LO] : mode_select_lo_r;
		multiproc_check_en_nxt = wr_mask[`BIT_MP_EN] ? wr_data[`BIT_MP_EN] : multiproc_check_en_r;
		rx_en_nxt = wr_mask[`BIT_RX_EN] ? wr_data[`BIT_RX_EN] : rx_en_r;
		tx_ninth_bit_nxt = wr_mask[`BIT_TX_NINTH] ? wr_data[`BIT_TX_NINTH] : tx_ninth_bit_r;
		rx_ninth_bit_nxt = wr_mask[`BIT_RX_NINTH] ? wr_data[`BIT_RX_NINTH] : rx_ninth_bit_r;
		if (rx_ninth_load) begin
			rx_ninth_bit_nxt = rx_ninth_val;
		end
		// Flags only ever clear through a software write
		tx_done_flag_nxt = wr_mask[`BIT_TX_DONE] ? wr_data[`BIT_TX_DONE] : tx_done_flag_r;
		rx_done_flag_nxt = wr_mask[`BIT_RX_DONE] ? wr_data[`BIT_RX_DONE] : rx_done_flag_r;
		if (tx_done_evt) begin
			tx_done_flag_nxt = 1'b1;
		end
		if (rx_load) begin
			rx_done_flag_nxt = 1'b1;
		end
	end

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mode_select_hi_r <= 1'b0;
			frame_error_flag_r <= 1'b0;
			mode_select_lo_r <= 1'b0;
			multiproc_check_en_r <= 1'b0;
			rx_en_r <= 1'b0;
			tx_ninth_bit_r <= 1'b0;
			rx_ninth_bit_r <= 1'b0;
			tx_done_flag_r <= 1'b0;
			rx_done_flag_r <= 1'b0;
		end else begin
			mode_select_hi_r <= mode_select_hi_nxt;
			frame_error_flag_r <= frame_error_flag_nxt;
			mode_select_lo_r <= mode_select_lo_nxt;
			multiproc_check_en_r <= multiproc_check_en_nxt;
			rx_en_r <= rx_en_nxt;
			tx_ninth_bit_r <= tx_ninth_bit_nxt;
			rx_ninth_bit_r <= rx_ninth_bit_nxt;
			tx_done_flag_r <= tx_done_flag_nxt;
			rx_done_flag_r <= rx_done_flag_nxt;
		end
	end

	assign o_irq = i_uart1_int_en && (tx_done_flag_r || rx_done_flag_r);

	// Registered read port; reading the buffer gives the receive side
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_sfr_rdata <= `UART1_BYTE_ZERO;
		end else if (ctrl_rd) begin
			o_sfr_rdata <= ctrl_view;
		end else if (buf_rd) begin
			o_sfr_rdata <= rx_buf_r;
		end
	end

	// Buffer writes queue bytes; a full queue drops the write
	uart1_fifo #(
		.W(TXQ_W),
		.D(TXQ_D),
		.AW(TXQ_AW)
	) u_txq (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_in_valid(buf_wr),
		.o_in_ready(o_txq_ready),
		.i_in_data(i_sfr_wdata),
		.o_out_valid(txq_valid),
		.i_out_ready(txq_pop),
		.o_out_data(txq_data)
	);

	assign txq_pop = (tx_state_r == TX_IDLE) && txq_valid;

	// Frame layout, sent lsb first; ninth bit sampled at load
	always @* begin
		case (mode)
			`MODE0: begin
				tx_frame = {3'h7, txq_data};
			end
			`MODE1: begin
				tx_frame = {2'h3, txq_data, 1'b0};
			end
			`MODE2, `MODE3: begin
				tx_frame = {1'b1, tx_ninth_bit_r, txq_data, 1'b0};
			end
			default: begin
				tx_frame = {3'h7, txq_data};
			end
		endcase
	end

	assign tx_done_evt = (tx_state_r == TX_SHIFT) && i_bit_tick && (tx_cnt_r == tx_done_at_r);

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tx_state_r <= TX_IDLE;
			tx_shift_r <= 11'h7FF;
			tx_cnt_r <= `CNT_ZERO;
			tx_len_r <= `LEN_SYNC;
			tx_done_at_r <= `LEN_SYNC;
			o_txd <= 1'b1;
		end else begin
			case (tx_state_r)
				TX_IDLE: begin
					o_txd <= 1'b1;
					if (txq_pop) begin
						tx_state_r <= TX_SHIFT;
						tx_shift_r <= tx_frame;
						tx_cnt_r <= `CNT_ZERO;
						// Mode 1 frames carry no ninth transmit bit
						if (mode == `MODE0) begin
							tx_len_r <= `LEN_SYNC;
							tx_done_at_r <= `LEN_SYNC;
						end else if (mode == `MODE1) begin
							tx_len_r <= `LEN_M1;
							tx_done_at_r <= `DONE_M1;
						end else begin
							tx_len_r <= `LEN_M23;
							tx_done_at_r <= `DONE_M23;
						end
					end
				end
				TX_SHIFT: begin
					if (i_bit_tick) begin
						if (tx_cnt_r == tx_len_r) begin
							tx_state_r <= TX_IDLE;
							o_txd <= 1'b1;
						end else begin
							o_txd <= tx_shift_r[0];
							tx_shift_r <= {1'b1, tx_shift_r[10:1]};
							tx_cnt_r <= tx_cnt_r + `CNT_ONE;
						end
					end
				end
				default: begin
					tx_state_r <= TX_IDLE;
				end
			endcase
		end
	end

	// Mode 0 waits for the done flag to clear; others wait for a start bit
	assign rx_start = (rx_state_r == RX_IDLE) && rx_en_r &&
		(((mode == `MODE0) && !rx_done_flag_r) ||
		((mode != `MODE0) && i_bit_tick && !i_rxd));

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_state_r <= RX_IDLE;
			rx_cnt_r <= `CNT_ZERO;
			rx_len_r <= `LEN_SYNC;
			rx_shift_r <= `UART1_BYTE_ZERO;
			rx_bit8_r <= 1'b0;
			rx_buf_r <= `UART1_BYTE_ZERO;
		end else begin
			case (rx_state_r)
				RX_IDLE: begin
					if (rx_start) begin
						rx_state_r <= RX_SHIFT;
						rx_cnt_r <= `CNT_ZERO;
						if (mode == `MODE0) begin
							rx_len_r <= `LEN_SYNC;
						end else if (mode == `MODE1) begin
							rx_len_r <= `RX_LEN_M1;
						end else begin
							rx_len_r <= `RX_LEN_M23;
						end
					end
				end
				RX_SHIFT: begin
					// Dropping the enable abandons the frame in progress
					if (!rx_en_r) begin
						rx_state_r <= RX_IDLE;
					end else if (i_bit_tick) begin
						if (rx_cnt_r < `CNT_DATA_END) begin
							rx_shift_r <= {i_rxd, rx_shift_r[7:1]};
						end else if (rx_cnt_r == `CNT_DATA_END) begin
							rx_bit8_r <= i_rxd;
						end
						rx_cnt_r <= rx_cnt_r + `CNT_ONE;
						if (rx_last) begin
							rx_state_r <= RX_IDLE;
						end
					end
				end
				default: begin
					rx_state_r <= RX_IDLE;
				end
			endcase
			if (rx_last && rx_load) begin
				// Mode 0 completes on its eighth sample, so include it
				rx_buf_r <= (mode == `MODE0) ? {i_rxd, rx_shift_r[7:1]} : rx_shift_r;
			end
		end
	end

	// Shift clock for mode 0 pulses low on each bit time while a frame shifts
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_sclk <= 1'b1;
		end else begin
			o_sclk <= !((mode == `MODE0) && i_bit_tick &&
				((tx_state_r == TX_SHIFT) || (rx_state_r == RX_SHIFT)));
		end
	end
endmodule // uart1_ctrl

`default_nettype wire

// ---- verification/uart1_ctrl_sva.sv ----
// Port assertions for the serial port 1 control block
`timescale 1ns/1ps
`default_nettype none
module uart1_ctrl_sva (
	// Clock, reset, bus
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic [7:0] i_sfr_wdata,
	input wire logic i_sfr_rd,
	input wire logic i_bit_wr,
	input wire logic i_uart1_int_en,
	input wire logic i_bit_tick,
	// Outputs
	input wire logic [7:0] o_sfr_rdata,
	input wire logic o_txq_ready,
	input wire logic o_txd,
	input wire logic o_sclk,
	input wire logic o_irq
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_irq_gated: assert property (!i_uart1_int_en |-> !o_irq)
		else $error("irq without enable");
	a_flag_sticky: assert property ((o_irq && !i_sfr_wr && !i_bit_wr) ##1 i_uart1_int_en
		|-> o_irq) else $error("done flag cleared by itself");
	a_rdata_hold: assert property (!$past(i_sfr_rd) |-> $stable(o_sfr_rdata))
		else $error("read data moved without read");
	a_unmapped_rd: assert property (i_sfr_rd && i_sfr_addr != 8'hF8 && i_sfr_addr != 8'h9A
		|=> $stable(o_sfr_rdata)) else $error("unmapped read changed data");
	a_ctrl_rdback: assert property ((i_sfr_wr && i_sfr_addr == 8'hF8) ##1
		(!i_sfr_wr && !i_bit_wr) ##1
		(i_sfr_rd && i_sfr_addr == 8'hF8 && !i_sfr_wr && !i_bit_wr)
		|=> o_sfr_rdata[6:3] == $past(i_sfr_wdata[6:3], 3)) else $error("control readback");
	a_txq_fill: assert property ($fell(o_txq_ready) |-> $past(i_sfr_wr && i_sfr_addr == 8'h9A))
		else $error("queue filled without write");
	a_txd_on_tick: assert property ($changed(o_txd) |-> $past(i_bit_tick))
		else $error("line moved off tick");
	a_sclk_pulse: assert property ($fell(o_sclk) |-> $past(i_bit_tick) ##1 o_sclk)
		else $error("shift clock pulse");
endmodule // uart1_ctrl_sva
bind uart1_ctrl uart1_ctrl_sva u_sva (.*);
`default_nettype wire

// ---- verification/uart1_node.sv ----
// Remote serial node: drives the receive line, captures sent frames
`timescale 1ns/1ps
`default_nettype none
module uart1_node (
	// Clock and timing
	input wire logic i_clk,
	input wire logic i_tick,
	// Frame to send, capture length
	input wire logic i_go,
	input wire logic [10:0] i_bits,
	input wire logic [3:0] i_nb,
	input wire logic [3:0] i_cn,
	// Line
	input wire logic i_txd,
	output logic o_rxd,
	output logic [9:0] o_cap
);
	logic [10:0] sh = 11'h7FF;
	logic [3:0] cnt = 4'h0;
	logic [3:0] ccnt = 4'h0;
	initial o_rxd = 1'b1;
	always @(posedge i_clk) begin
		if (i_go) begin
			sh <= i_bits;
			cnt <= i_nb;
		end else if (i_tick) begin
			// Pull-up holds the line high between frames
			o_rxd <= (cnt != 4'h0) ? sh[0] : 1'b1;
			sh <= sh >> 1;
			if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
		end
		if (i_tick && ccnt != 4'h0) begin
			o_cap[i_cn - ccnt] <= i_txd;
			ccnt <= ccnt - 4'h1;
		end else if (i_tick && !i_txd && i_cn != 4'h0)
			ccnt <= i_cn;
	end
endmodule // uart1_node
`default_nettype wire

// ---- verification/test_uart1_ctrl.sv ----
// Self-checking bench for the serial port 1 control block
`timescale 1ns/1ps
`default_nettype none
module test_uart1_ctrl;
	logic i_clk = 1'b0, i_rst = 1'b1, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, i_bit_wr = 1'b0;
	logic i_bit_val = 1'b0, fev = 1'b0, int_en = 1'b0, tick = 1'b0, ten = 1'b0, go = 1'b0;
	logic [7:0] addr = 8'h00, wd = 8'h00, rv, d, r, rdata;
	logic [2:0] bsel = 3'h0;
	logic [10:0] bits = 11'h7FF;
	logic [3:0] nb = 4'h0, cn = 4'h0;
	logic [1:0] tc = 2'h0;
	logic [31:0] seed = 32'hF;
	logic [9:0] cap;
	logic txq_ready, txd, sclk, irq, rxd, s, nin, mp, en, val, x;
	int fail_count = 0, checks_done = 0, cyc = 0, nf = 0, i, m;
	uart1_ctrl dut (.i_clk(i_clk), .i_rst(i_rst), .i_sfr_addr(addr), .i_sfr_wr(i_sfr_wr),
		.i_sfr_wdata(wd), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(rdata), .o_txq_ready(txq_ready),
		.i_bit_wr(i_bit_wr), .i_bit_addr(addr), .i_bit_sel(bsel), .i_bit_val(i_bit_val),
		.i_frame_err_view_sel(fev), .i_uart1_int_en(int_en), .i_slave_addr(8'hA5),
		.i_slave_mask(8'hFF), .i_bit_tick(tick), .i_rxd(rxd), .o_txd(txd), .o_sclk(sclk),
		.o_irq(irq));
	uart1_node node (.i_clk(i_clk), .i_tick(tick), .i_go(go), .i_bits(bits), .i_nb(nb),
		.i_cn(cn), .i_txd(txd), .o_rxd(rxd), .o_cap(cap));
	always #2 i_clk = ~i_clk;
	always @(negedge i_clk) begin
		tc <= tc + 2'h1;
		tick <= ten && tc == 2'h3;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (!sclk)
			nf++;
		if (cyc == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge i_clk);
		addr = a;
		wd = v;
		i_sfr_wr = 1'b1;
		@(negedge i_clk);
		i_sfr_wr = 1'b0;
	endtask
	task automatic bw(input logic [2:0] b, input logic v);
		@(negedge i_clk);
		addr = 8'hF8;
		bsel = b;
		i_bit_val = v;
		i_bit_wr = 1'b1;
		@(negedge i_clk);
		i_bit_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge i_clk);
		addr = a;
		i_sfr_rd = 1'b1;
		@(negedge i_clk);
		i_sfr_rd = 1'b0;
		rv = rdata;
	endtask
	task automatic waitt(input int n);
		repeat (n * 4) @(negedge i_clk);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge i_clk);
		i_rst = 1'b0;
		rd(8'hF8);
		chk("ctrl reset", rv, 8'h00);
		// Receive enable left out so no mode 0 reception starts here
		for (i = 0; i < 4; i++) begin
			d = rnd() & 8'hEC;
			wr(8'hF8, d);
			rd(8'hF8);
			chk("ctrl", rv, d);
			rd(8'h55);
			chk("unmapped", rv, d);
		end
		wr(8'hF8, 8'h00);
		fev = 1'b1;
		bw(3'h7, 1'b1);
		rd(8'hF8);
		chk("view fe", rv, 8'h80);
		fev = 1'b0;
		rd(8'hF8);
		chk("view mode", rv, 8'h00);
		$display("test registers done");
		ten = 1'b1;
		for (m = 0; m < 4; m++) begin
			x = rnd() > 8'h7F;
			d = rnd();
			int_en = 1'b0;
			wr(8'hF8, {m[1:0], 2'h0, x, 3'h0});
			cn = (m == 1) ? 4'h9 : (m > 1) ? 4'hA : 4'h0;
			wr(8'h9A, d);
			waitt(13);
			chk("irq masked", irq, 1'b0);
			int_en = 1'b1;
			if (m > 0)
				chk("frame", (m == 1) ? {1'b0, cap[8:0]} : cap, (m == 1) ? {2'b01, d} : {1'b1, x, d});
			rd(8'hF8);
			chk("tx done", rv[1], 1'b1);
			chk("irq", irq, 1'b1);
		end
		$display("test transmit done");
		cn = 4'h0;
		for (i = 0; i < 12; i++) begin
			r = rnd();
			m = 1 + r % 3;
			{mp, en, nin, s} = {r[2], r[3] | r[4], r[5], r[6] | r[7]};
			d = (mp && r[0]) ? (r[1] ? 8'hFF : 8'hA5) : rnd();
			val = en && (!mp || ((m == 1) ? s : nin) && (d == 8'hA5 || d == 8'hFF));
			fev = 1'b1;
			bw(3'h7, 1'b0);
			fev = 1'b0;
			wr(8'hF8, {m[1:0], mp, en, 4'h0});
			bits = (m == 1) ? {1'b1, s, d, 1'b0} : {s, nin, d, 1'b0};
			nb = (m == 1) ? 4'hA : 4'hB;
			@(negedge i_clk) go = 1'b1;
			@(negedge i_clk) go = 1'b0;
			waitt(14);
			fev = 1'b1;
			rd(8'hF8);
			fev = 1'b0;
			chk("rx done", rv[0], val);
			chk("frame err", rv[7], en & !s);
			if (val)
				chk("rx ninth", rv[2], (m == 1) ? s : nin);
			rd(8'h9A);
			if (val)
				chk("rx data", rv, d);
		end
		$display("test receive done");
		wr(8'hF8, 8'h11);
		nf = 0;
		waitt(12);
		chk("mode0 held", nf, 0);
		wr(8'hF8, 8'h30);
		waitt(12);
		chk("mode0 runs", nf != 0, 1'b1);
		wr(8'hF8, 8'h00);
		$display("test mode0 done");
		// Ticks stopped: the line stalls once the first byte is taken, so the queue can only fill
		ten = 1'b0;
		wr(8'hF8, 8'h40);
		for (i = 0; i < 17; i++) begin
			if (i == 16)
				chk("q room", txq_ready, 1'b1);
			wr(8'h9A, rnd());
		end
		chk("q full", txq_ready, 1'b0);
		ten = 1'b1;
		waitt(190);
		chk("q empty", txq_ready, 1'b1);
		$display("test queue done");
		end_of_test();
	end
endmodule // test_uart1_ctrl
`default_nettype wire
